// File: core/ahs_clk_div.sv
// Converter clock divider with a pulse on each rising edge
`timescale 1ns/100ps
module ahs_clk_div
    import ahs_pkg::*;
#(
    parameter int unsigned HALF_CYC = DIV_HALF_CYC
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    output logic adc_clk_out,
    output logic rise_out
);
    logic [CNT_W-1:0] div_reg;
    logic clk_reg;
    logic rise_reg;
    logic wrap;

    assign wrap = (div_reg == CNT_W'(HALF_CYC - 1));

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            div_reg <= '0;
            clk_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            div_reg <= wrap ? '0 : div_reg + CNT_W'(1);
            if (wrap) begin
                clk_reg <= ~clk_reg;
            end
            rise_reg <= wrap & ~clk_reg;
        end
    end

    assign adc_clk_out = clk_reg;
    assign rise_out = rise_reg;
endmodule : ahs_clk_div

// File: core/ahs_pkg.sv
// Shared constants and types for the converter strobe controller
package ahs_pkg;
    localparam int unsigned SYS_CLK_MHZ = 100;
    localparam int unsigned CHAN_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned TICK_W = 4;
    // CPU-like strobe width and analog settling time, in ns
    localparam int unsigned STROBE_NS = 500;
    localparam int unsigned SETTLE_NS = 2000;
    // Target converter clock in kHz
    localparam int unsigned ADC_CLK_KHZ = 1000;
    // Converter clock periods until conversion-done must be low
    localparam int unsigned EOC_LOW_PERIODS = 8;
    localparam int unsigned EOC_LOW_MARGIN = 2;

    // Least time in ns to whole cycles, rounded up, at least one
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * SYS_CLK_MHZ + 999) / 1000;
        return (c == 0) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int unsigned STROBE_CYC = ns_to_cyc(STROBE_NS);
    localparam int unsigned SETTLE_CYC = ns_to_cyc(SETTLE_NS);
    localparam int unsigned DIV_HALF_CYC =
        (SYS_CLK_MHZ * 1000) / (2 * ADC_CLK_KHZ);
    localparam logic [TICK_W-1:0] EOC_TIMEOUT_TICKS =
        TICK_W'(EOC_LOW_PERIODS + EOC_LOW_MARGIN);

    typedef enum logic [1:0] {
        SETTLE_SEPARATE,
        SETTLE_STRETCH,
        SETTLE_DOUBLE
    } ahs_settle_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LATCH,
        ST_SETTLE,
        ST_START,
        ST_WAIT_LOW,
        ST_WAIT_HIGH,
        ST_READ
    } ahs_st_t;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic ale;
        logic start;
        logic oe;
    } ahs_pins_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CHAN_W-1:0] chan;
    } ahs_result_t;

    typedef struct packed {
        ahs_st_t st;
        ahs_settle_t mode;
        ahs_pins_t pins;
        ahs_result_t result;
        logic res_valid;
        logic ready;
        logic busy;
        logic err;
        logic cont;
        logic second;
        logic chan_known;
        logic [CHAN_W-1:0] last_chan;
        logic [CNT_W-1:0] cnt;
        logic [TICK_W-1:0] ticks;
    } ahs_state_t;
endpackage : ahs_pkg

// File: core/ahs_strobe_ctrl.sv
// Host controller that drives the multiplexed converter's strobe pins
`timescale 1ns/100ps
module ahs_strobe_ctrl
    import ahs_pkg::*;
#(
    parameter int unsigned STROBE_CYCLES = STROBE_CYC,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
    parameter int unsigned DIV_HALF_CYCLES = DIV_HALF_CYC
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic [CHAN_W-1:0] req_chan_in,
    input wire ahs_settle_t req_mode_in,
    input wire logic req_cont_in,
    input wire logic cont_keep_in,
    output logic req_ready_out,
    output logic res_valid_out,
    output ahs_result_t res_out,
    output logic err_out,
    output logic busy_out,
    output ahs_pins_t adc_pins_out,
    output logic adc_clk_out,
    input wire logic adc_eoc_in,
    input wire logic [DATA_W-1:0] adc_data_in
);
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] STRETCH_LAST =
        CNT_W'(STROBE_CYCLES + SETTLE_CYCLES - 1);

    ahs_state_t state_reg;
    ahs_state_t state_next;
    logic adc_tick;
    logic cnt_done;

    ahs_clk_div #(
        .HALF_CYC(DIV_HALF_CYCLES)
    ) u_div (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .adc_clk_out(adc_clk_out),
        .rise_out(adc_tick)
    );

    assign cnt_done = (state_reg.cnt == '0);

    always_comb begin
        state_next = state_reg;
        state_next.res_valid = 1'b0;
        state_next.err = 1'b0;
        if (!cnt_done) begin
            state_next.cnt = state_reg.cnt - CNT_W'(1);
        end
        case (state_reg.st)
            ST_IDLE: begin
                if (req_valid_in) begin
                    state_next.ready = 1'b0;
                    state_next.busy = 1'b1;
                    state_next.mode = req_mode_in;
                    state_next.cont = req_cont_in;
                    state_next.second = 1'b0;
                    state_next.pins.chan = req_chan_in;
                    case (req_mode_in)
                        SETTLE_STRETCH: begin
                            // One long combined pulse covers settling
                            state_next.st = ST_START;
                            state_next.pins.ale = 1'b1;
                            state_next.pins.start = 1'b1;
                            state_next.cnt = STRETCH_LAST;
                        end
                        SETTLE_DOUBLE: begin
                            state_next.st = ST_START;
                            state_next.pins.ale = 1'b1;
                            state_next.pins.start = 1'b1;
                            state_next.cnt = STROBE_LAST;
                        end
                        default: begin
                            if (state_reg.chan_known &&
                                state_reg.last_chan == req_chan_in) begin
                                // Same channel: no latch, no settling
                                state_next.st = ST_START;
                                state_next.pins.start = 1'b1;
                            end else begin
                                state_next.st = ST_LATCH;
                                state_next.pins.ale = 1'b1;
                            end
                            state_next.cnt = STROBE_LAST;
                        end
                    endcase
                end
            end
            ST_LATCH: begin
                if (cnt_done) begin
                    state_next.pins.ale = 1'b0;
                    state_next.last_chan = state_reg.pins.chan;
                    state_next.chan_known = 1'b1;
                    state_next.st = ST_SETTLE;
                    state_next.cnt = SETTLE_LAST;
                end
            end
            ST_SETTLE: begin
                if (cnt_done) begin
                    state_next.st = ST_START;
                    state_next.pins.start = 1'b1;
                    // Second pulse reloads the same channel
                    state_next.pins.ale =
                        (state_reg.mode == SETTLE_DOUBLE);
                    state_next.cnt = STROBE_LAST;
                end
            end
            ST_START: begin
                if (cnt_done) begin
                    state_next.pins.ale = 1'b0;
                    state_next.pins.start = 1'b0;
                    state_next.last_chan = state_reg.pins.chan;
                    state_next.chan_known = 1'b1;
                    state_next.ticks = '0;
                    if (state_reg.mode == SETTLE_DOUBLE &&
                        !state_reg.second) begin
                        state_next.second = 1'b1;
                        state_next.st = ST_SETTLE;
                        state_next.cnt = SETTLE_LAST;
                    end else begin
                        state_next.st = ST_WAIT_LOW;
                    end
                end
            end
            ST_WAIT_LOW: begin
                // Done is trusted only after it has been seen low
                if (!adc_eoc_in) begin
                    state_next.st = ST_WAIT_HIGH;
                end else if (adc_tick) begin
                    state_next.ticks = state_reg.ticks + TICK_W'(1);
                    if (state_reg.ticks + TICK_W'(1) ==
                        EOC_TIMEOUT_TICKS) begin
                        state_next.err = 1'b1;
                        state_next.st = ST_IDLE;
                        state_next.ready = 1'b1;
                        state_next.busy = 1'b0;
                    end
                end
            end
            ST_WAIT_HIGH: begin
                if (adc_eoc_in) begin
                    state_next.st = ST_READ;
                    state_next.pins.oe = 1'b1;
                    // In continuous mode, start tied to output enable restarts conversion
                    state_next.pins.start = state_reg.cont;
                    state_next.cnt = STROBE_LAST;
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    state_next.pins.oe = 1'b0;
                    state_next.pins.start = 1'b0;
                    state_next.result.data = adc_data_in;
                    state_next.result.chan = state_reg.pins.chan;
                    state_next.res_valid = 1'b1;
                    state_next.ticks = '0;
                    if (state_reg.cont && cont_keep_in) begin
                        state_next.st = ST_WAIT_LOW;
                    end else begin
                        state_next.cont = 1'b0;
                        state_next.st = ST_IDLE;
                        state_next.ready = 1'b1;
                        state_next.busy = 1'b0;
                    end
                end
            end
            default: begin
                state_next.st = ST_IDLE;
                state_next.ready = 1'b1;
                state_next.busy = 1'b0;
                state_next.pins.ale = 1'b0;
                state_next.pins.start = 1'b0;
                state_next.pins.oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_reg <= '{
                st: ST_IDLE,
                mode: SETTLE_SEPARATE,
                pins: '0,
                result: '0,
                res_valid: 1'b0,
                ready: 1'b1,
                busy: 1'b0,
                err: 1'b0,
                cont: 1'b0,
                second: 1'b0,
                chan_known: 1'b0,
                last_chan: '0,
                cnt: '0,
                ticks: '0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_ready_out = state_reg.ready;
    assign res_valid_out = state_reg.res_valid;
    assign res_out = state_reg.result;
    assign err_out = state_reg.err;
    assign busy_out = state_reg.busy;
    assign adc_pins_out = state_reg.pins;
endmodule : ahs_strobe_ctrl

// File: testbench/ahs_adc_model.sv
// Behavioural model of the multiplexed converter
`timescale 1ns/100ps
module ahs_adc_model
    import ahs_pkg::*;
#(
    parameter int unsigned LOW_TICKS = 3,
    parameter int unsigned CONV_TICKS = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire ahs_pins_t pins_in,
    input wire logic adc_clk_in,
    input wire logic no_fall_in,
    output logic eoc_out,
    output logic [DATA_W-1:0] data_out
);
    logic ale_q_reg, clk_q_reg;
    logic [1:0] phase_reg;
    logic [3:0] chan_reg, n_reg;
    logic [DATA_W-1:0] result_reg;
    // Released bus shows the inverse of the result
    assign data_out = pins_in.oe ? result_reg : ~result_reg;
    always @(posedge clk_in) begin
        ale_q_reg <= pins_in.ale;
        clk_q_reg <= adc_clk_in;
        if (pins_in.ale && !ale_q_reg) begin
            chan_reg <= pins_in.chan;
        end
        if (rst_in) begin
            eoc_out <= 1'b1;
            phase_reg <= 2'h0;
        end else if (pins_in.start) begin
            phase_reg <= 2'h1;
            n_reg <= 4'h0;
        end else if (phase_reg != 2'h0 && adc_clk_in && !clk_q_reg) begin
            n_reg <= n_reg + 4'h1;
            if (phase_reg == 2'h1 && n_reg == LOW_TICKS - 1 && !no_fall_in) begin
                eoc_out <= 1'b0;
                phase_reg <= 2'h2;
                n_reg <= 4'h0;
            end else if (phase_reg == 2'h2 && n_reg == CONV_TICKS - 1) begin
                eoc_out <= 1'b1;
                result_reg <= {~chan_reg, chan_reg};
                phase_reg <= 2'h0;
            end
        end
    end
endmodule : ahs_adc_model

// File: testbench/ahs_strobe_chk.sv
// Property checker for the converter strobe controller
`timescale 1ns/100ps
module ahs_strobe_chk
    import ahs_pkg::*;
#(
    parameter int unsigned STROBE_CYCLES = STROBE_CYC,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
    parameter int unsigned DIV_HALF_CYCLES = DIV_HALF_CYC
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic [CHAN_W-1:0] req_chan_in,
    input wire ahs_settle_t req_mode_in,
    input wire logic req_cont_in,
    input wire logic cont_keep_in,
    input wire logic req_ready_out,
    input wire logic res_valid_out,
    input wire ahs_result_t res_out,
    input wire logic err_out,
    input wire logic busy_out,
    input wire ahs_pins_t adc_pins_out,
    input wire logic adc_clk_out,
    input wire logic adc_eoc_in,
    input wire logic [DATA_W-1:0] adc_data_in
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    logic [15:0] ale_n_reg, oe_n_reg, div_n_reg;
    logic clk_q_reg, seen_reg, flip;
    assign flip = adc_clk_out != clk_q_reg;
    // Run lengths of the latch and read strobes and of converter clock half periods
    always_ff @(posedge clk_sys_in) begin
        clk_q_reg <= adc_clk_out;
        seen_reg <= !sys_rst_in && (seen_reg || flip);
        div_n_reg <= (sys_rst_in || flip) ? 16'h1 : div_n_reg + 16'h1;
        ale_n_reg <= adc_pins_out.ale ? ale_n_reg + 16'h1 : 16'h0;
        oe_n_reg <= adc_pins_out.oe ? oe_n_reg + 16'h1 : 16'h0;
    end
    a_busy_inverse: assert property (busy_out == !req_ready_out)
        else $error("busy is not the inverse of ready");
    a_take_ready: assert property (req_valid_in && req_ready_out |=>
        !req_ready_out) else $error("ready stayed high after a take");
    a_ale_width: assert property ($fell(adc_pins_out.ale) |->
        ale_n_reg == 16'(STROBE_CYCLES) ||
        ale_n_reg == 16'(STROBE_CYCLES + SETTLE_CYCLES))
        else $error("latch pulse has the wrong width");
    a_oe_width: assert property ($fell(adc_pins_out.oe) |->
        oe_n_reg == 16'(STROBE_CYCLES)) else $error("read pulse width");
    a_read_after_done: assert property ($rose(adc_pins_out.oe) |->
        $past(adc_eoc_in)) else $error("read without done");
    a_result_on_read: assert property ($fell(adc_pins_out.oe) |->
        ##[0:1] res_valid_out) else $error("no result after read");
    a_chan_hold: assert property (!(req_valid_in && req_ready_out) |=>
        $stable(adc_pins_out.chan)) else $error("channel moved");
    a_idle_quiet: assert property (req_ready_out |->
        !adc_pins_out.ale && !adc_pins_out.start && !adc_pins_out.oe)
        else $error("strobe while idle");
    a_clk_half: assert property (seen_reg && flip |->
        div_n_reg == 16'(DIV_HALF_CYCLES)) else $error("clock half period");
endmodule : ahs_strobe_chk
bind ahs_strobe_ctrl ahs_strobe_chk #(.STROBE_CYCLES(STROBE_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES), .DIV_HALF_CYCLES(DIV_HALF_CYCLES)) u_chk (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid_in), .req_chan_in(req_chan_in),
    .req_mode_in(req_mode_in), .req_cont_in(req_cont_in),
    .cont_keep_in(cont_keep_in), .req_ready_out(req_ready_out),
    .res_valid_out(res_valid_out), .res_out(res_out), .err_out(err_out),
    .busy_out(busy_out), .adc_pins_out(adc_pins_out),
    .adc_clk_out(adc_clk_out), .adc_eoc_in(adc_eoc_in),
    .adc_data_in(adc_data_in));

// File: testbench/ahs_strobe_ctrl_tb.sv
// Self-checking bench for the converter strobe controller
`timescale 1ns/100ps
module ahs_strobe_ctrl_tb;
    import ahs_pkg::*;
    logic clk, rst, valid, cont, keep, no_fall, ready, rv, err, busy;
    logic aclk, eoc, ale_q, st_q;
    logic [3:0] chan;
    logic [7:0] data;
    ahs_settle_t mode;
    ahs_result_t res;
    ahs_pins_t pins;
    int num_errors = 0, comparisons = 0, cycles = 0;
    int n_res = 0, n_err = 0, n_ale = 0, n_start = 0;
    ahs_strobe_ctrl #(.STROBE_CYCLES(2), .SETTLE_CYCLES(4),
        .DIV_HALF_CYCLES(2)) dut (.clk_sys_in(clk), .sys_rst_in(rst),
        .req_valid_in(valid), .req_chan_in(chan), .req_mode_in(mode),
        .req_cont_in(cont), .cont_keep_in(keep), .req_ready_out(ready),
        .res_valid_out(rv), .res_out(res), .err_out(err), .busy_out(busy),
        .adc_pins_out(pins), .adc_clk_out(aclk), .adc_eoc_in(eoc),
        .adc_data_in(data));
    ahs_adc_model u_adc (.clk_in(clk), .rst_in(rst), .pins_in(pins),
        .adc_clk_in(aclk), .no_fall_in(no_fall), .eoc_out(eoc),
        .data_out(data));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_res += (rv === 1'b1);
        n_err += (err === 1'b1);
        n_ale += (pins.ale === 1'b1 && ale_q === 1'b0);
        n_start += (pins.start === 1'b1 && st_q === 1'b0);
        ale_q <= pins.ale;
        st_q <= pins.start;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic go(input logic [3:0] c, input ahs_settle_t m);
        for (int i = 0; i < 3000 && ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        valid = 1;
        chan = c;
        mode = m;
        @(posedge clk);
        #1 valid = 0;
    endtask : go
    task automatic wait_n(input int target);
        for (int i = 0; i < 3000 && n_res + n_err < target; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_n
    task automatic conv(input logic [3:0] c, input ahs_settle_t m,
        input int ea, es);
        int a0, s0;
        a0 = n_ale;
        s0 = n_start;
        go(c, m);
        wait_n(n_res + n_err + 1);
        chk("result data", 16'(res.data), 16'({~c, c}));
        chk("result chan", 16'(res.chan), 16'(c));
        chk("latch pulses", 16'(n_ale - a0), 16'(ea));
        chk("start pulses", 16'(n_start - s0), 16'(es));
    endtask : conv
    task automatic t_separate();
        conv(4'h5, SETTLE_SEPARATE, 1, 1);
        conv(4'h5, SETTLE_SEPARATE, 0, 1);
        conv(4'h0, ahs_settle_t'(2'h3), 1, 1);
    endtask : t_separate
    task automatic t_modes();
        conv(4'h9, SETTLE_STRETCH, 1, 1);
        conv(4'hf, SETTLE_DOUBLE, 2, 2);
    endtask : t_modes
    task automatic t_cont();
        int r0, s0;
        r0 = n_res;
        s0 = n_start;
        cont = 1;
        keep = 1;
        go(4'h3, SETTLE_SEPARATE);
        wait_n(n_res + n_err + 1);
        keep = 0;
        wait_n(n_res + n_err + 1);
        chk("cont results", 16'(n_res - r0), 16'h2);
        chk("cont starts", 16'(n_start - s0), 16'h3);
        chk("cont ready", 16'(ready), 16'h1);
        cont = 0;
    endtask : t_cont
    task automatic t_timeout();
        int r0, e0;
        r0 = n_res;
        e0 = n_err;
        no_fall = 1;
        go(4'h2, SETTLE_SEPARATE);
        wait_n(n_res + n_err + 1);
        chk("timeout flags", 16'(n_err - e0), 16'h1);
        chk("timeout results", 16'(n_res - r0), 16'h0);
        no_fall = 0;
        conv(4'h2, SETTLE_SEPARATE, 0, 1);
    endtask : t_timeout
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        {rst, valid, chan, cont, keep, no_fall} = 9'h100;
        mode = SETTLE_SEPARATE;
        repeat (8) @(posedge clk);
        #1;
        chk("reset pins", 16'({ready, pins}), 16'h80);
        chk("reset outs", 16'({busy, rv, err, aclk, res}), 16'h0);
        rst = 0;
        t_separate();
        t_modes();
        t_cont();
        t_timeout();
        stop_test();
    end
endmodule : ahs_strobe_ctrl_tb
